// ===== src/adcs_pkg.sv
package adcs_pkg;

  // Data widths and serial framing
  localparam int         RES_W          = 12;
  localparam int         CNT_W          = 4;
  localparam int         CTRL_W         = 8;
  localparam int         NIB_W          = 4;
  localparam logic [3:0] CTRL_BITS      = 4'h8;
  localparam logic [3:0] RISE_CMD_LAST  = 4'h3;
  localparam logic [3:0] RISE_CFG_LAST  = 4'h7;
  localparam logic [3:0] FALL_SAMPLE_ON = 4'h4;
  localparam logic [3:0] XFER_CLKS      = 4'hc;

  // Configuration nibble layout and reset values
  localparam int         CFG_EOC_BIT    = 3;
  localparam int         CFG_LSBF_BIT   = 2;
  localparam logic [3:0] CFG_RST        = 4'h0;
  localparam logic [3:0] CMD_RST        = 4'h0;

  // Conversion timing
  localparam int         CONV_TIME_NS   = 1600;
  localparam int         REF_CLK_MHZ    = 100;
  localparam int         CONV_CYCLES    = (CONV_TIME_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int         SEQ_CNT_W      = 16;

  typedef enum logic {
    ADCS_IDLE,
    ADCS_BUSY
  } adcs_seq_e;

  // Link domain, rising edge, cleared by chip select
  typedef struct packed {
    logic [CNT_W-1:0]  cnt;
    logic [CTRL_W-1:0] shift;
  } adcs_rise_s;

  // Link domain, rising edge, kept across frames
  typedef struct packed {
    logic [NIB_W-1:0] cmd;
    logic [NIB_W-1:0] cfg;
    logic [NIB_W-1:0] mux;
    logic             tgl;
  } adcs_keep_s;

  // Link domain, falling edge, cleared by chip select
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             sample;
  } adcs_fall_s;

  // Reference domain
  typedef struct packed {
    logic [2:0]       rise_sync;
    logic [2:0]       start_sync;
    logic [NIB_W-1:0] cfg;
    logic [RES_W-1:0] result;
    logic             status;
  } adcs_ref_s;

  typedef struct packed {
    adcs_seq_e            state;
    logic [SEQ_CNT_W-1:0] cnt;
    logic                 done;
  } adcs_seq_s;

endpackage : adcs_pkg

// ===== src/adcs_conv_seq.sv
`timescale 1ns/1ps
module adcs_conv_seq
  import adcs_pkg::*;
#(
  parameter int CYCLES = CONV_CYCLES
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Control
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  adcs_seq_s s_reg;
  adcs_seq_s s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    case (s_reg.state)
      ADCS_IDLE: begin
        if (start) begin
          s_next.state = ADCS_BUSY;
          s_next.cnt   = SEQ_CNT_W'(CYCLES - 1);
        end
      end
      ADCS_BUSY: begin
        if (s_reg.cnt == '0) begin
          s_next.state = ADCS_IDLE;
          s_next.done  = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end
      end
      default: s_next.state = ADCS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{state: ADCS_IDLE, cnt: '0, done: 1'b0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign busy = (s_reg.state == ADCS_BUSY);
  assign done = s_reg.done;

endmodule : adcs_conv_seq

// ===== src/adcs_top.sv
`timescale 1ns/1ps
// Functional notes
// - In interrupt mode the status pin falls once a conversion is done and its result is ready.
// - In interrupt mode a rising shift-clock edge returns the status pin high.
// - In end-of-conversion mode the status pin falls after the last falling shift edge of a frame.
// - In end-of-conversion mode the pin stays low until the conversion is done, then goes high.
// - Eight serial input bits are captured on the first eight rising shift edges.
// - The selector address is usable right after the fourth rising shift edge.
// - Sampling runs from the fourth falling shift edge to the last falling edge of the frame.
// - The remaining eleven bits of the previous result follow the first bit on the serial output.
// - The serial output changes only on falling shift edges.
// - At the last falling edge the internal sequencer takes over and converts unaided.
// - Chip select high clears the bit counters and input shift register; chip select falling opens the serial port.
// - With chip select high the output floats and the input and shift clock are ignored.
// - The input word arrives MSB first, four address or command bits then four config bits.
// - On chip select low the first result bit, MSB or LSB as set, is driven before any edge.
module adcs_top
  import adcs_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES
) (
  // Reference clock domain
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Serial link
  input  wire logic             sclk,
  input  wire logic             cs_n,
  input  wire logic             din,
  output logic                  dout_o,
  output logic                  dout_oe_o,
  // Analog front end
  output logic [NIB_W-1:0]      mux_addr_o,
  output logic                  sample_o,
  input  wire logic [RES_W-1:0] conv_data_i,
  output logic                  conv_busy_o,
  // Status and command
  output logic                  status_o,
  output logic [NIB_W-1:0]      cmd_nibble_o
);

  // Chip select high holds the framing logic idle
  logic       link_rst;
  assign link_rst = cs_n | ~rst_n;

  // Release of rst_n passes two flops so no reference flop
  // leaves reset close to a clock edge
  logic [1:0] rst_sync_reg;
  logic       ref_rst_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'b00;
    end else if (ce) begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign ref_rst_n = rst_sync_reg[1];

  adcs_rise_s rise_reg;
  adcs_rise_s rise_next;
  adcs_keep_s keep_reg;
  adcs_keep_s keep_next;
  adcs_fall_s fall_reg;
  adcs_fall_s fall_next;
  logic       start_tgl_reg;
  logic       start_tgl_next;
  adcs_ref_s  ref_reg;
  adcs_ref_s  ref_next;

  logic       rise_ev;
  logic       start_ev;
  logic       start_ok;
  logic       conv_done;
  logic       conv_busy;
  logic       conv_busy_reg;
  logic [3:0] fall_cnt_inc;

  // Rising edge: command capture
  always_comb begin
    rise_next     = rise_reg;
    keep_next     = keep_reg;
    keep_next.tgl = ~keep_reg.tgl;
    if (rise_reg.cnt < CTRL_BITS) begin
      rise_next.shift = {rise_reg.shift[CTRL_W-2:0], din};
      rise_next.cnt   = rise_reg.cnt + 4'h1;
    end
    if (rise_reg.cnt == RISE_CMD_LAST) begin
      keep_next.cmd = {rise_reg.shift[2:0], din};
      keep_next.mux = {rise_reg.shift[2:0], din};
    end
    if (rise_reg.cnt == RISE_CFG_LAST) begin
      keep_next.cfg = {rise_reg.shift[2:0], din};
    end
  end

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      rise_reg <= '0;
    end else begin
      rise_reg <= rise_next;
    end
  end

  // Config and toggle survive chip select so the crossing stays consistent
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      keep_reg <= '{cmd: CMD_RST, cfg: CFG_RST, mux: CMD_RST, tgl: 1'b0};
    end else if (!cs_n) begin
      keep_reg <= keep_next;
    end
  end

  // Falling edge: sampling window, bit index, handover
  assign fall_cnt_inc = fall_reg.cnt + 4'h1;

  always_comb begin
    fall_next      = fall_reg;
    start_tgl_next = start_tgl_reg;
    if (fall_reg.cnt < XFER_CLKS) begin
      fall_next.cnt = fall_cnt_inc;
      if (fall_cnt_inc == FALL_SAMPLE_ON) begin
        fall_next.sample = 1'b1;
      end
      if (fall_cnt_inc == XFER_CLKS) begin
        fall_next.sample = 1'b0;
        start_tgl_next   = ~start_tgl_reg;
      end
    end
  end

  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      fall_reg <= '0;
    end else begin
      fall_reg <= fall_next;
    end
  end

  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      start_tgl_reg <= 1'b0;
    end else if (!cs_n) begin
      start_tgl_reg <= start_tgl_next;
    end
  end

  // Result word is quasi-static: it only moves at conversion end, when no frame runs
  function automatic logic out_bit(input logic [RES_W-1:0] res,
                                   input logic [3:0]       idx,
                                   input logic             lsb_first);
    logic b;
    b = 1'b0;
    if (idx < XFER_CLKS) begin
      b = lsb_first ? res[idx] : res[4'(RES_W - 1) - idx];
    end
    return b;
  endfunction : out_bit

  // Order bit is the one stored with the result, so a frame that rewrites
  // the setting cannot reverse the word halfway through
  assign dout_o     = out_bit(ref_reg.result, fall_reg.cnt,
                              ref_reg.cfg[CFG_LSBF_BIT]);
  assign dout_oe_o  = ~cs_n;
  assign mux_addr_o = keep_reg.mux;
  assign sample_o   = fall_reg.sample;
  assign cmd_nibble_o = keep_reg.cmd;

  // Reference domain: event crossings by toggle, stage 0 read only by stage 1
  assign rise_ev  = ref_reg.rise_sync[2] ^ ref_reg.rise_sync[1];
  assign start_ev = ref_reg.start_sync[2] ^ ref_reg.start_sync[1];
  // A start while converting is dropped whole, mode and status included
  assign start_ok = start_ev & ~conv_busy;

  adcs_conv_seq #(
    .CYCLES (CONV_CYC)
  ) u_seq (
    .ref_clk (ref_clk),
    .rst_n   (ref_rst_n),
    .ce      (ce),
    .start   (start_ok),
    .busy    (conv_busy),
    .done    (conv_done)
  );

  always_comb begin
    ref_next            = ref_reg;
    ref_next.rise_sync  = {ref_reg.rise_sync[1:0], keep_reg.tgl};
    ref_next.start_sync = {ref_reg.start_sync[1:0], start_tgl_reg};
    if (start_ok) begin
      ref_next.cfg = keep_reg.cfg;
      if (keep_reg.cfg[CFG_EOC_BIT]) begin
        ref_next.status = 1'b0;
      end
    end
    if (rise_ev && !ref_reg.cfg[CFG_EOC_BIT]) begin
      ref_next.status = 1'b1;
    end
    // Done after the clear, so an edge in the same cycle cannot lose the flag
    if (conv_done) begin
      ref_next.result = conv_data_i;
      ref_next.status = ref_reg.cfg[CFG_EOC_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge ref_rst_n) begin
    if (!ref_rst_n) begin
      ref_reg       <= '{rise_sync: 3'h0, start_sync: 3'h0, cfg: CFG_RST,
                         result: '0, status: 1'b1};
      conv_busy_reg <= 1'b0;
    end else if (ce) begin
      ref_reg       <= ref_next;
      conv_busy_reg <= conv_busy;
    end
  end

  assign status_o    = ref_reg.status;
  assign conv_busy_o = conv_busy_reg;

endmodule : adcs_top

// ===== testbench/adcs_top_assertions.sv
`timescale 1ns/1ps
module adcs_top_assertions
  import adcs_pkg::*;
(
  // Clock and reset
  input wire logic             ref_clk,
  input wire logic             rst_n,
  // Serial link
  input wire logic             sclk,
  input wire logic             cs_n,
  input wire logic             dout_o,
  input wire logic             dout_oe_o,
  // Front end and status
  input wire logic [NIB_W-1:0] mux_addr_o,
  input wire logic             sample_o,
  input wire logic             conv_busy_o,
  input wire logic             status_o
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_oe_follow_cs: assert property (dout_oe_o == !cs_n)
    else $error("output enable off chip select");
  chk_idle_quiet: assert property (cs_n |-> !sample_o)
    else $error("sampling while deselected");
  chk_dout_hold: assert property (sclk && $past(sclk) && !cs_n && !$past(cs_n) |-> $stable(dout_o))
    else $error("serial output moved while clock high");
  chk_mux_hold: assert property (!sclk && !$past(sclk) |-> $stable(mux_addr_o))
    else $error("selector moved without rising edge");
  chk_sample_start: assert property ($rose(sample_o) |-> !sclk && !cs_n)
    else $error("sampling began off a falling edge");
  chk_handover_busy: assert property ($fell(sample_o) && !cs_n |-> ##[1:8] conv_busy_o)
    else $error("sequencer did not take over");
  chk_done_status: assert property ($fell(conv_busy_o) |-> ##[0:2] $changed(status_o))
    else $error("status unchanged at completion");
  chk_int_clear: assert property ($rose(sclk) && !status_o && !conv_busy_o |-> ##[1:6] status_o)
    else $error("status not cleared by shift clock");
endmodule : adcs_top_assertions

bind adcs_top adcs_top_assertions chk_inst (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk),
  .cs_n(cs_n), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .mux_addr_o(mux_addr_o),
  .sample_o(sample_o), .conv_busy_o(conv_busy_o), .status_o(status_o));

// ===== testbench/adcs_host_model.sv
`timescale 1ns/1ps
module adcs_host_model (
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // Fixed 12-clock frame, mode 0; odd offset keeps edges off the reference clock
  task automatic xfer(input logic [7:0] word, output logic [11:0] got);
    #7 cs_n = 1'b0;
    for (int i = 0; i < 12; i++) begin
      din = (i < 8) ? word[7-i] : ~din;
      #80 sclk = 1'b1;
      got = {got[10:0], dout};
      #80 sclk = 1'b0;
    end
    din = ~din;
    #80 cs_n = 1'b1;
  endtask : xfer
  // Clocks while deselected, only when a scenario asks
  task automatic stray(input int n);
    repeat (n) begin
      din = ~din;
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
  endtask : stray
endmodule : adcs_host_model

// ===== testbench/adcs_top_bench.sv
`timescale 1ns/1ps
module adcs_top_bench;
  import adcs_pkg::*;
  logic             ref_clk, rst_n, ce, sclk, cs_n, din, dout_o, dout_oe_o;
  logic             sample_o, conv_busy_o, status_o;
  logic [NIB_W-1:0] mux_addr_o, cmd_nibble_o;
  logic [RES_W-1:0] conv_data_i, got;
  wire logic        link_dout;
  int               error_cnt = 0;
  int               total_checks = 0;
  // Floating output shows the inverse so a stale bit never passes
  assign link_dout = dout_oe_o ? dout_o : ~dout_o;
  adcs_top #(.CONV_CYC(40)) adcs_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .mux_addr_o(mux_addr_o), .sample_o(sample_o), .conv_data_i(conv_data_i),
    .conv_busy_o(conv_busy_o), .status_o(status_o), .cmd_nibble_o(cmd_nibble_o));
  adcs_host_model adcs_host_model_inst (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(link_dout));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [11:0] rev(input logic [11:0] v);
    for (int i = 0; i < 12; i++) rev[i] = v[11-i];
  endfunction : rev
  task automatic frame(input logic [7:0] word, input logic [11:0] data, input logic [11:0] exp);
    @(posedge ref_clk) conv_data_i <= data;
    adcs_host_model_inst.xfer(word, got);
    @(negedge ref_clk);
    check("readback", got, exp);
    check("selector", mux_addr_o, word[7:4]);
    check("command", cmd_nibble_o, word[7:4]);
    check("enable", dout_oe_o, 1'b0);
  endtask : frame
  task automatic wait_done;
    for (int i = 0; i < 200 && conv_busy_o !== 1'b0; i++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
  endtask : wait_done
  task automatic t_int_mode;
    frame(8'h50, 12'ha5c, 12'h000);
    check("int busy", status_o, 1'b1);
    wait_done;
    check("int done", status_o, 1'b0);
  endtask : t_int_mode
  // Mode switch mid-stream; stray clocks must not reach the command
  task automatic t_eoc_mode;
    frame(8'ha8, 12'h3c1, 12'ha5c);
    check("eoc busy", status_o, 1'b0);
    wait_done;
    check("eoc done", status_o, 1'b1);
    adcs_host_model_inst.stray(3);
    check("stray", cmd_nibble_o, 4'ha);
  endtask : t_eoc_mode
  // Order follows the configuration stored one frame back
  task automatic t_lsb_order;
    frame(8'hf4, 12'h0c1, 12'h3c1);
    wait_done;
    frame(8'h30, 12'h000, rev(12'h0c1));
    check("int clear", status_o, 1'b1);
    wait_done;
    check("last done", status_o, 1'b0);
  endtask : t_lsb_order
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    conv_data_i = 12'h000;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_int_mode;
    t_eoc_mode;
    t_lsb_order;
    summarize;
  end
  // Four frames take about 10 us
  initial begin
    #60000;
    error_cnt++;
    summarize;
  end
endmodule : adcs_top_bench
